// ==== src/adc_conversion_sequencer.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Trigger rising edge puts track/hold into hold and starts a conversion.
// - Busy output rises together with hold, three clock edges after the trigger edge, and stays high throughout conversion.
// - External clock pin high at trigger edge selects the external clock.
// - External clock pin low at trigger edge selects the internal oscillator.
// - External-clock conversions take sixteen clock edges; internal ones take CONV_CYCLES (55) system clock cycles.
// - At end of conversion busy falls and track/hold returns to tracking.
// - After busy falls, result is read on 14-bit bus with chip select, read.
// - Data outputs are enabled only while read and chip select are low.
// - Trigger level at conversion end decides how the busy output behaves.
// - With internal oscillator a conversion completes in 2.2 us.
// - Observing that read schedule, throughput reaches up to 400 kHz.
// - Hold is entered on the third system clock edge after the trigger edge, behind the two-stage synchroniser.
module adc_conversion_sequencer
   import adc_seq_pkg::*;
   (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              conversion_trigger,
   input  wire logic              external_conversion_clock,
   input  wire logic              cs_n,
   input  wire logic              rd_n,
   input  wire logic [DATA_W-1:0] sampled_code,
   output      logic              conversion_busy,
   output      logic              track_hold_hold,
   output      logic [DATA_W-1:0] data_out,
   output      logic              data_oe,
   output      logic              trigger_dropped
   );

   // Whole state of the sequencer in one struct
   typedef struct packed {
      pin_sync_t         sync1;
      pin_sync_t         sync2;
      logic              trig_prev;
      logic              ext_prev;
      logic              rd_act_prev;
      seq_state_t        state;
      logic              ext_sel;
      logic [CNT_W-1:0]  cyc_cnt;
      logic [CNT_W-1:0]  edge_cnt;
      logic              push;
      logic [DATA_W-1:0] code;
      result_t           result;
      logic              busy;
      logic              hold;
      logic [DATA_W-1:0] dout;
      logic              oe;
      logic              dropped;
   } seq_reg_t;

   seq_reg_t          r_q;
   seq_reg_t          r_d;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic [DATA_W-1:0] fifo_out_data;
   logic              trig_rise;
   logic              ext_rise;
   logic              rd_act;
   logic              read_end;
   logic              conv_done;

   // One step of either conversion counter; callers guard the end value
   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
      bump = v + CNT_W'(1);
   endfunction : bump

   // Edges are taken from the second stage only
   assign trig_rise = r_q.sync2.trig && !r_q.trig_prev;
   assign ext_rise  = r_q.sync2.ext_clk && !r_q.ext_prev;
   assign rd_act    = !r_q.sync2.cs_n && !r_q.sync2.rd_n;
   assign read_end  = r_q.rd_act_prev && !rd_act;

   // Done after sixteen external clock edges, or CONV_CYCLES system clocks on the internal source
   always_comb
   begin
      conv_done = 1'b0;
      if (r_q.state == ST_CONVERT)
      begin
         if (r_q.ext_sel)
         begin
            conv_done = ext_rise && (r_q.cyc_cnt >= CNT_W'(EXT_QUIET_CYC))
                        && (r_q.edge_cnt == CNT_W'(CONV_CLOCKS - 1));
         end
         else
         begin
            conv_done = (r_q.cyc_cnt == CNT_W'(CONV_CYCLES - 1));
         end
      end
   end

   // Drain side: take the next word when the bus word is free or just read
   assign fifo_out_ready = !r_q.result.valid || read_end;

   result_fifo
      #(.WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH))
   u_fifo
      (.clk_sys   (clk_sys),
       .reset     (reset),
       .in_valid  (r_q.push),
       .in_ready  (fifo_in_ready),
       .in_data   (r_q.code),
       .out_valid (fifo_out_valid),
       .out_ready (fifo_out_ready),
       .out_data  (fifo_out_data));

   // Next-state logic for the whole sequencer
   always_comb
   begin
      r_d             = r_q;
      r_d.sync1       = '{trig: conversion_trigger, ext_clk: external_conversion_clock,
                          cs_n: cs_n, rd_n: rd_n};
      r_d.sync2       = r_q.sync1;
      r_d.trig_prev   = r_q.sync2.trig;
      r_d.ext_prev    = r_q.sync2.ext_clk;
      r_d.rd_act_prev = rd_act;
      r_d.push        = 1'b0;
      r_d.dropped     = 1'b0;

      case (r_q.state)
         ST_IDLE:
         begin
            // A full result queue refuses the trigger rather than lose a word
            if (trig_rise && fifo_in_ready)
            begin
               r_d.state    = ST_CONVERT;
               r_d.hold     = 1'b1;
               r_d.busy     = 1'b1;
               r_d.ext_sel  = r_q.sync2.ext_clk;
               r_d.code     = sampled_code;
               r_d.cyc_cnt  = CNT_RESET;
               r_d.edge_cnt = CNT_RESET;
            end
            else if (trig_rise)
            begin
               r_d.dropped = 1'b1;
            end
         end
         ST_CONVERT:
         begin
            // Edges inside the quiet window are ignored
            if (r_q.cyc_cnt != '1)
            begin
               r_d.cyc_cnt = bump(r_q.cyc_cnt);
            end
            if (ext_rise && (r_q.cyc_cnt >= CNT_W'(EXT_QUIET_CYC)))
            begin
               r_d.edge_cnt = bump(r_q.edge_cnt);
            end
            if (conv_done)
            begin
               r_d.busy = 1'b0;
               r_d.hold = 1'b0;
               r_d.push = 1'b1;
               // Trigger still high selects end-of-conversion pulse form
               r_d.state = r_q.sync2.trig ? ST_EOC_LOW : ST_IDLE;
            end
            else if (trig_rise)
            begin
               r_d.dropped = 1'b1;
            end
         end
         ST_EOC_LOW:
         begin
            // One cycle low marks the end, then the pin rests high
            r_d.busy  = 1'b1;
            r_d.state = ST_EOC_WAIT;
         end
         ST_EOC_WAIT:
         begin
            // Pin returns low once the trigger is released
            if (!r_q.sync2.trig)
            begin
               r_d.busy  = 1'b0;
               r_d.state = ST_IDLE;
            end
         end
         default:
         begin
            r_d.state = ST_IDLE;
         end
      endcase

      // Bus word follows the queue head
      if (fifo_out_ready)
      begin
         r_d.result.valid = fifo_out_valid;
         r_d.result.code  = fifo_out_valid ? fifo_out_data : r_q.result.code;
      end

      // Drive the bus only while both selects are low
      r_d.oe   = rd_act;
      r_d.dout = rd_act ? r_q.result.code : DATA_RESET;
   end

   // State register; synchronous reset to idle, tracking
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         r_q                 <= '0;
         r_q.sync1.cs_n      <= 1'b1;
         r_q.sync1.rd_n      <= 1'b1;
         r_q.sync2.cs_n      <= 1'b1;
         r_q.sync2.rd_n      <= 1'b1;
         r_q.state           <= ST_IDLE;
         r_q.cyc_cnt         <= CNT_RESET;
         r_q.edge_cnt        <= CNT_RESET;
         r_q.code            <= DATA_RESET;
         r_q.result.code     <= DATA_RESET;
         r_q.dout            <= DATA_RESET;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // Outputs straight from flops
   assign conversion_busy = r_q.busy;
   assign track_hold_hold = r_q.hold;
   assign data_out        = r_q.dout;
   assign data_oe         = r_q.oe;
   assign trigger_dropped = r_q.dropped;

endmodule : adc_conversion_sequencer

// ==== src/adc_seq_pkg.sv ====
package adc_seq_pkg;

   // Result width and clock figures
   localparam int unsigned DATA_W          = 14;
   localparam int unsigned FIFO_DEPTH      = 16;
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned CONV_CLOCKS     = 16;
   // Internal conversion time, in nanoseconds
   localparam int unsigned CONV_TIME_NS    = 2200;
   // Longest time, rounded down to whole cycles
   localparam int unsigned CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
   // Hold entry delay, typical, in nanoseconds
   localparam int unsigned HOLD_DELAY_NS   = 15;
   localparam int unsigned HOLD_CYCLES     = (HOLD_DELAY_NS / CLK_PERIOD_NS) > 0 ?
                                             (HOLD_DELAY_NS / CLK_PERIOD_NS) : 1;
   // External clock quiet time after the trigger edge
   localparam int unsigned EXT_QUIET_NS    = 100;
   localparam int unsigned EXT_QUIET_CYC   = (EXT_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 6;
   localparam logic [CNT_W-1:0] CNT_RESET  = 6'h00;
   localparam logic [DATA_W-1:0] DATA_RESET = 14'h0000;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_EOC_LOW,
      ST_EOC_WAIT
   } seq_state_t;

   // Two-stage synchroniser bank for the pins
   typedef struct packed {
      logic trig;
      logic ext_clk;
      logic cs_n;
      logic rd_n;
   } pin_sync_t;

   // One result word on its way to the bus
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] code;
   } result_t;

endpackage : adc_seq_pkg

// ==== src/result_fifo.sv ====
`timescale 1ns/1ps
module result_fifo
   #(parameter int unsigned WIDTH = 14,
     parameter int unsigned DEPTH = 16)
   (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
   );

   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
   } fifo_state_t;

   logic [WIDTH-1:0] mem_q [DEPTH];
   fifo_state_t      st_q;
   fifo_state_t      st_d;
   logic             push;
   logic             pop;

   // Honest flags from the occupancy count
   assign in_ready  = (st_q.count != (AW+1)'(DEPTH));
   assign out_valid = (st_q.count != '0);
   assign out_data  = mem_q[st_q.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb
   begin
      st_d = st_q;
      if (push)
      begin
         st_d.wr_ptr = st_q.wr_ptr + AW'(1);
      end
      if (pop)
      begin
         st_d.rd_ptr = st_q.rd_ptr + AW'(1);
      end
      if (push && !pop)
      begin
         st_d.count = st_q.count + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         st_d.count = st_q.count - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Storage needs no reset; count guards it
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem_q[st_q.wr_ptr] <= in_data;
      end
   end

endmodule : result_fifo

// ==== test/adc_conversion_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top
   import adc_seq_pkg::*;
   ;
   logic              clk_sys, reset, conversion_trigger, external_conversion_clock, cs_n, rd_n;
   logic              conversion_busy, track_hold_hold, data_oe, trigger_dropped;
   logic [DATA_W-1:0] sampled_code, data_out, last_w, w;
   logic [DATA_W-1:0] exp_q[$];
   int                failures, cmp_count, drops, exp_drops;

   // 25 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   adc_conversion_sequencer dut (.clk_sys(clk_sys), .reset(reset), .conversion_trigger(conversion_trigger),
      .external_conversion_clock(external_conversion_clock), .cs_n(cs_n), .rd_n(rd_n),
      .sampled_code(sampled_code), .conversion_busy(conversion_busy), .track_hold_hold(track_hold_hold),
      .data_out(data_out), .data_oe(data_oe), .trigger_dropped(trigger_dropped));
   adc_host_model hm (.clk_sys(clk_sys), .conversion_busy(conversion_busy), .data_oe(data_oe),
      .data_out(data_out), .conversion_trigger(conversion_trigger),
      .external_conversion_clock(external_conversion_clock), .cs_n(cs_n), .rd_n(rd_n));

   // Refusal pulses seen at the port, sampled off the launching edge
   always @(negedge clk_sys)
      if (trigger_dropped === 1'b1)
         drops++;

   task automatic results;
      if (failures == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_count(input int got, input int exp);
      cmp_count++;
      if (got != exp)
      begin
         failures++;
         $display("mismatch %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_count

   // Random code held across the capture, inverted afterwards to expose late capture
   task automatic conv(input bit ext, input bit keep, input bit glitch);
      logic [DATA_W-1:0] c;
      int                n;
      bit                eoc;
      c            = DATA_W'($urandom);
      sampled_code = c;
      hm.convert(ext, keep, glitch, n, eoc);
      sampled_code = ~c;
      // Queue plus the word parked on the bus register hold one more than the depth
      if (exp_q.size() < FIFO_DEPTH + 1)
         exp_q.push_back(c);
      else
         exp_drops++;
      if (glitch)
         exp_drops++;
      if (keep)
         chk_count(int'(eoc), 1);
      else if (!ext && !glitch && n != 0)
         chk_count(n, CONV_CYCLES);
   endtask : conv

   // Reads come out oldest first; an empty queue repeats the last word
   task automatic rd_chk;
      hm.read(w);
      if (exp_q.size() > 0)
         last_w = exp_q.pop_front();
      chk_word(w, last_w);
   endtask : rd_chk

   // About 2050 cycles expected; cut off well beyond
   initial
   begin
      #(12000 * CLK_PERIOD_NS);
      failures++;
      results();
   end

   initial
   begin
      reset        = 1'b1;
      sampled_code = '0;
      last_w       = '0;
      void'($urandom(38));
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      repeat (4) @(negedge clk_sys);
      repeat (3) conv(0, 0, 0);
      repeat (3) rd_chk();
      repeat (2) conv(1, 0, 0);
      repeat (2) rd_chk();
      conv(0, 0, 1);
      conv(0, 1, 0);
      repeat (3) rd_chk();
      repeat (18) conv(0, 0, 0);
      repeat (16) rd_chk();
      chk_count(drops, exp_drops);
      results();
   end
endmodule : adc_conversion_sequencer_tb_top

// ==== test/adc_host_model.sv ====
`timescale 1ns/1ps
module adc_host_model
   import adc_seq_pkg::*;
   (
   input  wire logic              clk_sys,
   input  wire logic              conversion_busy,
   input  wire logic              data_oe,
   input  wire logic [DATA_W-1:0] data_out,
   output      logic              conversion_trigger,
   output      logic              external_conversion_clock,
   output      logic              cs_n,
   output      logic              rd_n
   );
   // Pins idle until the first request
   initial
   begin
      conversion_trigger        = 1'b0;
      external_conversion_clock = 1'b0;
      cs_n                      = 1'b1;
      rd_n                      = 1'b1;
   end

   // One conversion; keep holds the trigger past the end, glitch retriggers mid-way
   task automatic convert(input bit ext, input bit keep, input bit glitch, output int n, output bit eoc);
      int i;
      n   = 0;
      eoc = 0;
      @(negedge clk_sys);
      external_conversion_clock <= ext;
      repeat (8) @(negedge clk_sys); // Acquisition wait, no reads here
      conversion_trigger <= 1'b1;
      for (i = 0; i < 8 && conversion_busy !== 1'b1; i++) @(negedge clk_sys);
      conversion_trigger <= keep;
      if (glitch)
      begin
         repeat (10) @(negedge clk_sys);
         conversion_trigger <= 1'b1;
         repeat (2) @(negedge clk_sys);
         conversion_trigger <= 1'b0;
      end
      // Clock only after the quiet time, then stands still high
      if (ext)
      begin
         repeat (6) @(negedge clk_sys);
         repeat (16)
         begin
            external_conversion_clock <= 1'b0;
            repeat (4) @(negedge clk_sys);
            external_conversion_clock <= 1'b1;
            repeat (4) @(negedge clk_sys);
         end
      end
      while (conversion_busy === 1'b1 && n < 400)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (keep)
      begin
         @(negedge clk_sys);
         eoc = (conversion_busy === 1'b1);
         conversion_trigger <= 1'b0;
         repeat (6) @(negedge clk_sys);
         eoc = eoc && (conversion_busy === 1'b0);
      end
   endtask : convert

   // Read strobe held until the bus answers, only between conversions
   task automatic read(output logic [DATA_W-1:0] w);
      int i;
      @(negedge clk_sys);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      for (i = 0; i < 8 && data_oe !== 1'b1; i++) @(negedge clk_sys);
      w = data_out;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (6) @(negedge clk_sys);
   endtask : read
endmodule : adc_host_model

// ==== test/adc_seq_checker.sv ====
`timescale 1ns/1ps
module adc_seq_checker
   import adc_seq_pkg::*;
   (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              conversion_trigger,
   input  wire logic              external_conversion_clock,
   input  wire logic              cs_n,
   input  wire logic              rd_n,
   input  wire logic              conversion_busy,
   input  wire logic              track_hold_hold,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe,
   input  wire logic              trigger_dropped
   );
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic       ext_p1, ext_p2, hold_p, ext_mode_q;
   logic [4:0] edges_q;

   // Source and raw clock edges, relearned at each hold entry
   always_ff @(posedge clk_sys)
   begin
      ext_p1 <= external_conversion_clock;
      ext_p2 <= ext_p1;
      hold_p <= track_hold_hold;
      if (reset || (track_hold_hold && !hold_p))
      begin
         ext_mode_q <= ext_p2 && !reset;
         edges_q    <= 5'h00;
      end
      else if (external_conversion_clock && !ext_p1 && edges_q != 5'h1F)
         edges_q <= edges_q + 5'h01;
   end

   // Idle trigger edge, and an internal run from its first cycle
   sequence s_start;
      !conversion_busy ##1 ($rose(conversion_trigger) && !conversion_busy);
   endsequence
   sequence s_int_run;
      $rose(track_hold_hold) && !$past(external_conversion_clock, 2);
   endsequence

   a_trig_start: assert property (s_start |-> ##[1:5] (track_hold_hold || trigger_dropped))
      else $error("idle trigger edge neither started nor was refused");
   a_hold_busy: assert property ($rose(track_hold_hold) |-> $rose(conversion_busy))
      else $error("hold entered without busy rising");
   a_busy_covers: assert property (track_hold_hold |-> conversion_busy)
      else $error("busy low while holding");
   a_int_time: assert property (s_int_run |-> (track_hold_hold throughout ##54 1'b1) ##1 !track_hold_hold)
      else $error("internal conversion length wrong");
   a_ext_edges: assert property ($fell(track_hold_hold) && ext_mode_q |-> edges_q == 5'h10)
      else $error("external conversion did not end after sixteen edges");
   a_end_together: assert property ($fell(track_hold_hold) |-> $fell(conversion_busy))
      else $error("tracking and busy fall apart");
   a_eoc_form: assert property ((conversion_trigger[*5] ##0 $fell(conversion_busy)) |=> conversion_busy)
      else $error("busy not raised again with trigger high at end");
   a_read_window: assert property (data_oe == $past(!cs_n && !rd_n, 3))
      else $error("bus enable does not follow select and read");
   a_bus_idle: assert property (!data_oe |-> data_out == '0)
      else $error("data bus not quiet while disabled");
   a_drop_busy: assert property ($rose(conversion_trigger) && conversion_busy
                                 |-> (##[1:5] trigger_dropped) or (##[1:5] !conversion_busy))
      else $error("trigger during conversion not refused");
endmodule : adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker chk (
   .clk_sys(clk_sys), .reset(reset), .conversion_trigger(conversion_trigger),
   .external_conversion_clock(external_conversion_clock), .cs_n(cs_n), .rd_n(rd_n),
   .conversion_busy(conversion_busy), .track_hold_hold(track_hold_hold), .data_out(data_out),
   .data_oe(data_oe), .trigger_dropped(trigger_dropped));
